// ### sysref_clock_control_regs.sv
// clock-control register group with sysref controls and position status
`timescale 1ns/10ps
module sysref_clock_control_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic sdi_i,
  input wire logic sysref_i,
  input wire logic [sysref_clk_pkg::POS_W-1:0] edge_position_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic reset_busy_o,
  output logic sysref_event_o,
  output logic sysref_processor_on_o,
  output logic sysref_receiver_on_o,
  output logic sysref_fine_window_o,
  output logic [sysref_clk_pkg::SEL_W-1:0] sysref_delay_choice_o,
  output logic sysref_polarity_flip_o,
  output logic sysref_pecl_input_mode_o,
  output logic device_clock_pecl_input_mode_o,
  output logic analog_supply_quieting_on_o,
  output logic clock_supply_quieting_on_o
);
  // ************************************************************
  // soft reset and quiet time
  // ************************************************************
  logic [sysref_clk_pkg::BUSY_W-1:0] busy_cnt_ff;
  logic int_rst;
  // registers and port are held while the quiet time runs
  assign int_rst = rst_i | soft_reset_i | reset_busy_o; // RULE_18
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      busy_cnt_ff <= '0;
      reset_busy_o <= 1'b0;
    end
    else if (soft_reset_i)
    begin
      busy_cnt_ff <= sysref_clk_pkg::BUSY_W'(sysref_clk_pkg::RESET_QUIET_CYC - 1); // RULE_18
      reset_busy_o <= 1'b1;
    end
    else if (reset_busy_o)
    begin
      busy_cnt_ff <= busy_cnt_ff - sysref_clk_pkg::BUSY_W'(1);
      // self-clearing once the count runs out
      if (busy_cnt_ff == '0)
      begin
        reset_busy_o <= 1'b0;
      end
    end
  end
  // ************************************************************
  // serial port
  // ************************************************************
  sysref_clk_pkg::reg_req_t req;
  logic [sysref_clk_pkg::ADDR_W-1:0] rd_addr;
  logic [sysref_clk_pkg::BYTE_W-1:0] rd_data;
  spi_serial_port u_port (
    .mclk_i(mclk_i),
    .rst_i(int_rst),
    .sclk_i(sclk_i),
    .csn_i(csn_i),
    .sdi_i(sdi_i),
    .rd_data_i(rd_data),
    .req_o(req),
    .rd_addr_o(rd_addr),
    .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n_o)
  );
  // ************************************************************
  // control registers
  // ************************************************************
  // reserved bits are stored as written; software keeps them at default
  logic [sysref_clk_pkg::BYTE_W-1:0] ctrl_zero_ff, ctrl_one_ff, ctrl_two_ff;
  always_ff @(posedge mclk_i)
  begin
    if (int_rst)
    begin
      ctrl_zero_ff <= sysref_clk_pkg::CTRL_ZERO_RST; // RULE_01
    end
    else if (req.wr && req.addr == sysref_clk_pkg::CTRL_ZERO_OFS)
    begin
      ctrl_zero_ff <= req.data; // RULE_19
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (int_rst)
    begin
      ctrl_one_ff <= sysref_clk_pkg::CTRL_ONE_RST; // RULE_09
    end
    else if (req.wr && req.addr == sysref_clk_pkg::CTRL_ONE_OFS)
    begin
      ctrl_one_ff <= req.data; // RULE_19
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (int_rst)
    begin
      ctrl_two_ff <= sysref_clk_pkg::CTRL_TWO_RST; // RULE_13
    end
    else if (req.wr && req.addr == sysref_clk_pkg::CTRL_TWO_OFS)
    begin
      ctrl_two_ff <= req.data; // RULE_19
    end
  end
  assign sysref_processor_on_o = ctrl_zero_ff[sysref_clk_pkg::PROC_BIT]; // RULE_02
  assign sysref_receiver_on_o = ctrl_zero_ff[sysref_clk_pkg::RECV_BIT]; // RULE_04
  assign sysref_fine_window_o = ctrl_zero_ff[sysref_clk_pkg::ZOOM_BIT]; // RULE_05
  assign sysref_delay_choice_o = ctrl_zero_ff[sysref_clk_pkg::SEL_HI:sysref_clk_pkg::SEL_LO]; // RULE_07
  assign sysref_polarity_flip_o = ctrl_one_ff[sysref_clk_pkg::INV_BIT]; // RULE_10
  assign sysref_pecl_input_mode_o = ctrl_one_ff[sysref_clk_pkg::SYS_PECL_BIT]; // RULE_12
  assign device_clock_pecl_input_mode_o = ctrl_one_ff[sysref_clk_pkg::DEV_PECL_BIT]; // RULE_11
  assign analog_supply_quieting_on_o = ctrl_two_ff[sysref_clk_pkg::ANA_Q_BIT]; // RULE_14
  assign clock_supply_quieting_on_o = ctrl_two_ff[sysref_clk_pkg::CLK_Q_BIT]; // RULE_15
  // ************************************************************
  // sysref path and position status
  // ************************************************************
  logic [sysref_clk_pkg::POS_W-1:0] position;
  sysref_event_path u_sysref (
    .mclk_i(mclk_i),
    .rst_i(int_rst),
    .sysref_i(sysref_i),
    .edge_position_i(edge_position_i),
    .receiver_on_i(sysref_receiver_on_o),
    .processor_on_i(sysref_processor_on_o),
    .polarity_flip_i(sysref_polarity_flip_o),
    .event_o(sysref_event_o),
    .position_o(position)
  );
  // ************************************************************
  // read mux
  // ************************************************************
  // the position word spans three byte addresses, low byte first; no write path
  always_comb
  begin
    rd_data = 8'h00;
    unique case (rd_addr)
      sysref_clk_pkg::CTRL_ZERO_OFS: rd_data = ctrl_zero_ff;
      sysref_clk_pkg::CTRL_ONE_OFS: rd_data = ctrl_one_ff;
      sysref_clk_pkg::CTRL_TWO_OFS: rd_data = ctrl_two_ff;
      sysref_clk_pkg::POS_OFS: rd_data = position[7:0]; // RULE_16
      sysref_clk_pkg::POS_MID_OFS: rd_data = position[15:8]; // RULE_17
      sysref_clk_pkg::POS_TOP_OFS: rd_data = position[23:16]; // RULE_17
      default: rd_data = 8'h00;
    endcase
  end
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic wr_zero;
  assign wr_zero = req.wr && req.addr == sysref_clk_pkg::CTRL_ZERO_OFS;
  logic wr_one, wr_two, calm, pos_wr;
  assign wr_one = req.wr && req.addr == sysref_clk_pkg::CTRL_ONE_OFS;
  assign wr_two = req.wr && req.addr == sysref_clk_pkg::CTRL_TWO_OFS;
  // soft reset and the quiet time override any write in flight
  assign calm = !soft_reset_i && !reset_busy_o;
  assign pos_wr = req.wr && req.addr inside {sysref_clk_pkg::POS_OFS,
    sysref_clk_pkg::POS_MID_OFS, sysref_clk_pkg::POS_TOP_OFS};
  sequence s_soft_start;
    soft_reset_i ##1 reset_busy_o;
  endsequence
  sequence s_soft_hold;
    reset_busy_o [*8];
  endsequence
  property p_zero_default;
    $rose(soft_reset_i) |=> ctrl_zero_ff == 8'h80;
  endproperty
  a_zero_default: assert property (p_zero_default) else $error("ctrl zero not 0x80"); // RULE_01
  property p_one_two_default;
    soft_reset_i |=> ctrl_one_ff == 8'h00 && ctrl_two_ff == 8'h10;
  endproperty
  a_one_two_default: assert property (p_one_two_default) else $error("ctrl defaults wrong"); // RULE_13
  property p_event_gated;
    sysref_event_o |-> $past(sysref_processor_on_o) && $past(sysref_receiver_on_o);
  endproperty
  a_event_gated: assert property (p_event_gated) else $error("event while gated off"); // RULE_02
  property p_zero_write;
    wr_zero && !soft_reset_i && !reset_busy_o |=> ctrl_zero_ff == $past(req.data);
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("ctrl zero write lost"); // RULE_19
  property p_zero_hold;
    !wr_zero && !soft_reset_i && !reset_busy_o |=> $stable(ctrl_zero_ff);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("ctrl zero changed"); // RULE_19
  property p_pos_ro;
    pos_wr && !sysref_receiver_on_o && calm |=> $stable(position);
  endproperty
  a_pos_ro: assert property (p_pos_ro) else $error("position took a write"); // RULE_16
  property p_soft_busy;
    s_soft_start |-> ##1 s_soft_hold;
  endproperty
  a_soft_busy: assert property (p_soft_busy) else $error("quiet time too short"); // RULE_18
  property p_soft_end;
    $rose(reset_busy_o) |-> ##186 reset_busy_o ##1 !reset_busy_o;
  endproperty
  a_soft_end: assert property (p_soft_end) else $error("quiet time length wrong"); // RULE_18
  property p_sel_reset;
    $past(soft_reset_i) |-> sysref_delay_choice_o == 4'h0 && !sysref_receiver_on_o;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("sel or receiver not reset"); // RULE_07
  // ************************************************************
  // field checks
  // ************************************************************
  property p_one_write;
    wr_one && calm |=> ctrl_one_ff == $past(req.data);
  endproperty
  a_one_write: assert property (p_one_write) else $error("ctrl one write lost"); // RULE_19
  property p_one_hold;
    !wr_one && calm |=> $stable(ctrl_one_ff);
  endproperty
  a_one_hold: assert property (p_one_hold) else $error("ctrl one changed"); // RULE_19
  property p_two_write;
    wr_two && calm |=> ctrl_two_ff == $past(req.data);
  endproperty
  a_two_write: assert property (p_two_write) else $error("ctrl two write lost"); // RULE_19
  property p_two_hold;
    !wr_two && calm |=> $stable(ctrl_two_ff);
  endproperty
  a_two_hold: assert property (p_two_hold) else $error("ctrl two changed"); // RULE_19
  property p_one_outs_reset;
    soft_reset_i |=> !sysref_polarity_flip_o && !sysref_pecl_input_mode_o
      && !device_clock_pecl_input_mode_o;
  endproperty
  a_one_outs_reset: assert property (p_one_outs_reset) else $error("mode not off"); // RULE_11
  property p_two_outs_reset;
    soft_reset_i |=> !analog_supply_quieting_on_o && !clock_supply_quieting_on_o;
  endproperty
  a_two_outs_reset: assert property (p_two_outs_reset) else $error("quieting on"); // RULE_14
  property p_flip_follow;
    wr_one && calm
      |=> sysref_polarity_flip_o == $past(req.data[sysref_clk_pkg::INV_BIT]);
  endproperty
  a_flip_follow: assert property (p_flip_follow) else $error("flip wrong"); // RULE_10
  property p_sys_pecl_follow;
    wr_one && calm
      |=> sysref_pecl_input_mode_o == $past(req.data[sysref_clk_pkg::SYS_PECL_BIT]);
  endproperty
  a_sys_pecl_follow: assert property (p_sys_pecl_follow) else $error("pecl wrong"); // RULE_12
  property p_dev_pecl_follow;
    wr_one && calm
      |=> device_clock_pecl_input_mode_o == $past(req.data[sysref_clk_pkg::DEV_PECL_BIT]);
  endproperty
  a_dev_pecl_follow: assert property (p_dev_pecl_follow) else $error("clk pecl wrong"); // RULE_11
  property p_ana_follow;
    wr_two && calm
      |=> analog_supply_quieting_on_o == $past(req.data[sysref_clk_pkg::ANA_Q_BIT]);
  endproperty
  a_ana_follow: assert property (p_ana_follow) else $error("analog quieting wrong"); // RULE_14
  property p_clk_q_follow;
    wr_two && calm
      |=> clock_supply_quieting_on_o == $past(req.data[sysref_clk_pkg::CLK_Q_BIT]);
  endproperty
  a_clk_q_follow: assert property (p_clk_q_follow) else $error("clock quieting wrong"); // RULE_15
  property p_proc_follow;
    wr_zero && calm
      |=> sysref_processor_on_o == $past(req.data[sysref_clk_pkg::PROC_BIT]);
  endproperty
  a_proc_follow: assert property (p_proc_follow) else $error("processor bit wrong"); // RULE_02
  property p_recv_follow;
    wr_zero && calm
      |=> sysref_receiver_on_o == $past(req.data[sysref_clk_pkg::RECV_BIT]);
  endproperty
  a_recv_follow: assert property (p_recv_follow) else $error("receiver bit wrong"); // RULE_04
  property p_zoom_follow;
    wr_zero && calm
      |=> sysref_fine_window_o == $past(req.data[sysref_clk_pkg::ZOOM_BIT]);
  endproperty
  a_zoom_follow: assert property (p_zoom_follow) else $error("zoom bit wrong"); // RULE_05
  property p_sel_follow;
    wr_zero && calm
      |=> sysref_delay_choice_o == $past(req.data[sysref_clk_pkg::SEL_HI:sysref_clk_pkg::SEL_LO]);
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("delay choice wrong"); // RULE_07
  property p_zoom_reset;
    soft_reset_i |=> !sysref_fine_window_o && !sysref_processor_on_o;
  endproperty
  a_zoom_reset: assert property (p_zoom_reset) else $error("zoom or processor on"); // RULE_05
  // ************************************************************
  // sysref path and quiet time checks
  // ************************************************************
  property p_proc_off;
    !sysref_processor_on_o |=> !sysref_event_o;
  endproperty
  a_proc_off: assert property (p_proc_off) else $error("event with processor off"); // RULE_02
  property p_event_single;
    sysref_event_o |=> !sysref_event_o;
  endproperty
  a_event_single: assert property (p_event_single) else $error("event too long"); // RULE_02
  property p_recv_off_pos;
    !sysref_receiver_on_o && calm |=> $stable(position);
  endproperty
  a_recv_off_pos: assert property (p_recv_off_pos) else $error("position moved"); // RULE_04
  property p_pos_cleared;
    soft_reset_i |=> position == sysref_clk_pkg::POS_RST;
  endproperty
  a_pos_cleared: assert property (p_pos_cleared) else $error("position not cleared"); // RULE_16
  property p_busy_no_write;
    reset_busy_o |-> !req.wr;
  endproperty
  a_busy_no_write: assert property (p_busy_no_write) else $error("write while busy"); // RULE_18
  property p_busy_port_off;
    reset_busy_o |-> sdo_oe_n_o;
  endproperty
  a_busy_port_off: assert property (p_busy_port_off) else $error("sdo driven while busy"); // RULE_18
endmodule // sysref_clock_control_regs

// ### sysref_clk_pkg.sv
// constants, field positions and carrier types for the sysref clock-control register group
// Contract
// (RULE_01) first control register resets 0x80, reserved top bit
// (RULE_02) bit 6 enables sysref event processing
// (RULE_03) host enables receiver before or with processor
// (RULE_04) bit 5 turns receiver on, resets off
// (RULE_05) bit 4 selects finer windowing delay steps
// (RULE_06) host sets zoom when several windows valid
// (RULE_07) bits 3:0 choose sysref delay, reset zero
// (RULE_08) host picks delay from position status readback
// (RULE_09) second control register resets 0x00, reserved 7:3
// (RULE_10) second register bit 0 inverts used sysref
// (RULE_11) second register bit 2 device clock pecl mode
// (RULE_12) second register bit 1 sysref pecl mode
// (RULE_13) third control register resets 0x10
// (RULE_14) third register bit 2 analog supply quieting
// (RULE_15) third register bit 0 clock supply quieting
// (RULE_16) position register at 0x2C, read-only, resets zero
// (RULE_17) position register returns 24-bit edge status word
// (RULE_18) soft reset restores defaults, 750 ns quiet time
// (RULE_19) fields read back and drive functions continuously
package sysref_clk_pkg;
  localparam int ADDR_W = 15;
  localparam int BYTE_W = 8;
  localparam int POS_W = 24;
  localparam int SEL_W = 4;
  localparam int HDR_BITS = 16;
  localparam logic [ADDR_W-1:0] CTRL_ZERO_OFS = 15'h0029;
  localparam logic [ADDR_W-1:0] CTRL_ONE_OFS = 15'h002A;
  localparam logic [ADDR_W-1:0] CTRL_TWO_OFS = 15'h002B;
  localparam logic [ADDR_W-1:0] POS_OFS = 15'h002C;
  localparam logic [ADDR_W-1:0] POS_MID_OFS = 15'h002D;
  localparam logic [ADDR_W-1:0] POS_TOP_OFS = 15'h002E;
  localparam logic [BYTE_W-1:0] CTRL_ZERO_RST = 8'h80;
  localparam logic [BYTE_W-1:0] CTRL_ONE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] CTRL_TWO_RST = 8'h10;
  localparam logic [POS_W-1:0] POS_RST = 24'h000000;
  localparam int PROC_BIT = 6;
  localparam int RECV_BIT = 5;
  localparam int ZOOM_BIT = 4;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 0;
  localparam int INV_BIT = 0;
  localparam int SYS_PECL_BIT = 1;
  localparam int DEV_PECL_BIT = 2;
  localparam int ANA_Q_BIT = 2;
  localparam int CLK_Q_BIT = 0;
  localparam int MCLK_MHZ = 250;
  localparam int RESET_QUIET_NS = 750;
  // longest time, so floor division
  localparam int RESET_QUIET_CYC = (RESET_QUIET_NS * MCLK_MHZ) / 1000;
  localparam int BUSY_W = 8;
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } reg_req_t;
endpackage

// ### spi_serial_port.sv
// serial register port: header of read flag and 15-bit address, then streamed bytes
`timescale 1ns/10ps
module spi_serial_port (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic sdi_i,
  input wire logic [sysref_clk_pkg::BYTE_W-1:0] rd_data_i,
  output sysref_clk_pkg::reg_req_t req_o,
  output logic [sysref_clk_pkg::ADDR_W-1:0] rd_addr_o,
  output logic sdo_o,
  output logic sdo_oe_n_o
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // sclk must stay below mclk/8 so each edge is seen after sync delay
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic csn_s1_ff, csn_s2_ff;
  logic sdi_s1_ff, sdi_s2_ff;
  always_ff @(posedge mclk_i)
  begin
    sclk_s1_ff <= sclk_i;
    sclk_s2_ff <= sclk_s1_ff;
    sclk_s3_ff <= sclk_s2_ff;
    csn_s1_ff <= csn_i;
    csn_s2_ff <= csn_s1_ff;
    sdi_s1_ff <= sdi_i;
    sdi_s2_ff <= sdi_s1_ff;
  end
  logic rise, fall, idle;
  assign rise = sclk_s2_ff & ~sclk_s3_ff;
  assign fall = ~sclk_s2_ff & sclk_s3_ff;
  assign idle = rst_i | csn_s2_ff;
  // ************************************************************
  // frame shifter
  // ************************************************************
  logic [sysref_clk_pkg::HDR_BITS-1:0] hdr_ff;
  logic [sysref_clk_pkg::BYTE_W-1:0] dat_ff, out_ff;
  logic [4:0] cnt_ff;
  logic in_data_ff, rd_ff, load_ff;
  logic [sysref_clk_pkg::HDR_BITS-1:0] nxt_hdr;
  assign nxt_hdr = {hdr_ff[sysref_clk_pkg::HDR_BITS-2:0], sdi_s2_ff};
  always_ff @(posedge mclk_i)
  begin
    req_o.wr <= 1'b0;
    load_ff <= 1'b0;
    if (idle)
    begin
      cnt_ff <= 5'h00;
      in_data_ff <= 1'b0;
      rd_ff <= 1'b0;
      hdr_ff <= '0;
      dat_ff <= 8'h00;
      rd_addr_o <= '0;
      req_o.addr <= '0;
      req_o.data <= 8'h00;
    end
    else if (rise && !in_data_ff)
    begin
      hdr_ff <= nxt_hdr;
      cnt_ff <= cnt_ff + 5'h01;
      if (cnt_ff == 5'(sysref_clk_pkg::HDR_BITS - 1))
      begin
        in_data_ff <= 1'b1;
        cnt_ff <= 5'h00;
        rd_ff <= nxt_hdr[sysref_clk_pkg::HDR_BITS-1];
        rd_addr_o <= nxt_hdr[sysref_clk_pkg::ADDR_W-1:0];
        load_ff <= 1'b1;
      end
    end
    else if (rise)
    begin
      dat_ff <= {dat_ff[sysref_clk_pkg::BYTE_W-2:0], sdi_s2_ff};
      cnt_ff <= cnt_ff + 5'h01;
      if (cnt_ff == 5'(sysref_clk_pkg::BYTE_W - 1))
      begin
        cnt_ff <= 5'h00;
        req_o.wr <= ~rd_ff;
        req_o.addr <= rd_addr_o;
        req_o.data <= {dat_ff[sysref_clk_pkg::BYTE_W-2:0], sdi_s2_ff};
        // streaming always ascends
        rd_addr_o <= rd_addr_o + 15'h0001;
        load_ff <= 1'b1;
      end
    end
  end
  // ************************************************************
  // read data out, changed on falling sclk
  // ************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (idle)
    begin
      out_ff <= 8'h00;
      sdo_o <= 1'b0;
      sdo_oe_n_o <= 1'b1;
    end
    else if (load_ff)
    begin
      out_ff <= rd_data_i;
      sdo_oe_n_o <= ~rd_ff;
    end
    else if (fall && in_data_ff)
    begin
      sdo_o <= out_ff[sysref_clk_pkg::BYTE_W-1];
      out_ff <= {out_ff[sysref_clk_pkg::BYTE_W-2:0], 1'b0};
    end
  end
endmodule // spi_serial_port

// ### sysref_event_path.sv
// sysref pin conditioning: sync, polarity, gating and edge position capture
`timescale 1ns/10ps
module sysref_event_path (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sysref_i,
  input wire logic [sysref_clk_pkg::POS_W-1:0] edge_position_i,
  input wire logic receiver_on_i,
  input wire logic processor_on_i,
  input wire logic polarity_flip_i,
  output logic event_o,
  output logic [sysref_clk_pkg::POS_W-1:0] position_o
);
  logic sr_s1_ff, sr_s2_ff, sr_prev_ff;
  logic [sysref_clk_pkg::POS_W-1:0] pos_s1_ff, pos_s2_ff;
  always_ff @(posedge mclk_i)
  begin
    sr_s1_ff <= sysref_i;
    sr_s2_ff <= sr_s1_ff;
    pos_s1_ff <= edge_position_i;
    pos_s2_ff <= pos_s1_ff;
  end
  logic sr_used, sr_rise;
  assign sr_used = sr_s2_ff ^ polarity_flip_i; // RULE_10
  assign sr_rise = sr_used & ~sr_prev_ff & receiver_on_i;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sr_prev_ff <= 1'b0;
      event_o <= 1'b0;
      position_o <= sysref_clk_pkg::POS_RST; // RULE_16
    end
    else
    begin
      sr_prev_ff <= sr_used;
      // processor off: edges are seen but never passed on
      event_o <= sr_rise & processor_on_i; // RULE_02
      if (sr_rise)
      begin
        position_o <= pos_s2_ff; // RULE_17
      end
    end
  end
endmodule // sysref_event_path

// ### spi_host_model.sv
// host-side serial master model for the register port
`timescale 1ns/10ps
module spi_host_model (
  input wire logic mclk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i,
  output logic sclk_o,
  output logic csn_o,
  output logic sdi_o
);
  // ********************
  // frame engine
  // ********************
  int oe_bad = 0;
  initial
  begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    sdi_o = 1'b0;
  end
  // half sclk period of 5 mclk keeps the port's pin syncs comfortable
  task automatic half();
    repeat (5) @(posedge mclk_i);
    #1;
  endtask
  // bytes go low byte first, to ascending addresses
  task automatic frame(input logic rd, input logic [14:0] a, input int nb,
                       input logic [23:0] wd, output logic [23:0] rdo);
    logic [39:0] bits;
    bits = {rd, a, wd[7:0], wd[15:8], wd[23:16]};
    rdo = '0;
    half();
    csn_o = 1'b0;
    for (int i = 0; i < 16 + 8 * nb; i++)
    begin
      sdi_o = bits[39 - i];
      half();
      sclk_o = 1'b1;
      if (i >= 16)
      begin
        // an undriven line reads inverted so a missing enable is caught
        rdo[8 * ((i - 16) / 8) + 7 - (i % 8)] = sdo_oe_n_i ? ~sdo_i : sdo_i;
        if (rd && sdo_oe_n_i !== 1'b0)
          oe_bad++;
      end
      half();
      sclk_o = 1'b0;
    end
    half();
    csn_o = 1'b1;
    // released line shows the inverse so a stale sample is caught
    sdi_o = ~sdi_o;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule // spi_host_model

// ### sysref_clock_control_regs_test.sv
// self-checking bench for the sysref clock-control register group
`timescale 1ns/10ps
`define CHK(g, e) cmp(24'(g), 24'(e))
module sysref_clock_control_regs_test;
  // ********************
  // signals and instances
  // ********************
  logic mclk_i, rst_i, soft_reset_i, sclk_i, csn_i, sdi_i, sysref_i;
  logic [sysref_clk_pkg::POS_W-1:0] edge_position_i;
  logic sdo_o, sdo_oe_n_o, reset_busy_o, sysref_event_o, sysref_processor_on_o;
  logic sysref_receiver_on_o, sysref_fine_window_o, sysref_polarity_flip_o;
  logic [sysref_clk_pkg::SEL_W-1:0] sysref_delay_choice_o;
  logic sysref_pecl_input_mode_o, device_clock_pecl_input_mode_o;
  logic analog_supply_quieting_on_o, clock_supply_quieting_on_o;
  logic [11:0] outs;
  int n_fail = 0;
  int checked = 0;
  int n_ev = 0;
  assign outs = {sysref_processor_on_o, sysref_receiver_on_o, sysref_fine_window_o,
    sysref_delay_choice_o, sysref_polarity_flip_o, sysref_pecl_input_mode_o,
    device_clock_pecl_input_mode_o, analog_supply_quieting_on_o, clock_supply_quieting_on_o};
  sysref_clock_control_regs DUT (.mclk_i, .rst_i, .soft_reset_i, .sclk_i, .csn_i, .sdi_i,
    .sysref_i, .edge_position_i, .sdo_o, .sdo_oe_n_o, .reset_busy_o, .sysref_event_o,
    .sysref_processor_on_o, .sysref_receiver_on_o, .sysref_fine_window_o,
    .sysref_delay_choice_o, .sysref_polarity_flip_o, .sysref_pecl_input_mode_o,
    .device_clock_pecl_input_mode_o, .analog_supply_quieting_on_o,
    .clock_supply_quieting_on_o);
  spi_host_model host (.mclk_i, .sdo_i(sdo_o), .sdo_oe_n_i(sdo_oe_n_o), .sclk_o(sclk_i),
    .csn_o(csn_i), .sdi_o(sdi_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
    if (sysref_event_o === 1'b1)
      n_ev <= n_ev + 1;
  // ********************
  // helpers
  // ********************
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic reg_wr(input logic [14:0] a, input int nb, input logic [23:0] d);
    logic [23:0] r;
    host.frame(1'b0, a, nb, d, r);
    step(6);
  endtask
  task automatic reg_rd(input logic [14:0] a, input int nb, output logic [23:0] r);
    host.frame(1'b1, a, nb, 24'h000000, r);
  endtask
  task automatic regs_are(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2);
    logic [23:0] r;
    `CHK(outs, {c0[6], c0[5], c0[4], c0[3:0], c1[0], c1[1], c1[2], c2[2], c2[0]});
    reg_rd(sysref_clk_pkg::CTRL_ZERO_OFS, 3, r);
    `CHK(r, {c2, c1, c0});
  endtask
  task automatic pulse(input logic [23:0] p, input int ev, input logic [23:0] ep);
    int n0;
    logic [23:0] r;
    edge_position_i = p;
    n0 = n_ev;
    step(4);
    sysref_i = 1'b1;
    step(10);
    sysref_i = 1'b0;
    step(10);
    `CHK(n_ev - n0, ev);
    reg_rd(sysref_clk_pkg::POS_OFS, 3, r);
    `CHK(r, ep);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_defaults();
    logic [23:0] r;
    regs_are(8'h80, 8'h00, 8'h10);
    reg_rd(sysref_clk_pkg::POS_OFS, 3, r);
    `CHK(r, 24'h000000);
    reg_rd(15'h0100, 1, r);
    `CHK(r, 24'h000000);
  endtask
  task automatic t_fields();
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 1, 24'h0000A0);
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 3, 24'h1507F5);
    regs_are(8'hF5, 8'h07, 8'h15);
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 3, 24'h1402EA);
    regs_are(8'hEA, 8'h02, 8'h14);
  endtask
  task automatic t_sysref();
    logic [23:0] r;
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 1, 24'h000080);
    reg_wr(sysref_clk_pkg::CTRL_ONE_OFS, 1, 24'h000001);
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 1, 24'h0000A0);
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 1, 24'h0000E0);
    pulse(24'hA5C3E1, 1, 24'hA5C3E1);
    reg_wr(sysref_clk_pkg::CTRL_ONE_OFS, 1, 24'h000000);
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 1, 24'h0000A0);
    pulse(24'h3C5A69, 0, 24'h3C5A69);
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 1, 24'h000080);
    pulse(24'h96E187, 0, 24'h3C5A69);
    reg_wr(sysref_clk_pkg::POS_OFS, 3, 24'hFFFFFF);
    reg_rd(sysref_clk_pkg::POS_OFS, 3, r);
    `CHK(r, 24'h3C5A69);
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 1, 24'h000099);
    `CHK(sysref_fine_window_o, 1'b1);
    `CHK(sysref_delay_choice_o, 4'h9);
  endtask
  task automatic t_soft();
    int cnt;
    reg_wr(sysref_clk_pkg::CTRL_ZERO_OFS, 3, 24'h1507F5);
    soft_reset_i = 1'b1;
    step(1);
    soft_reset_i = 1'b0;
    `CHK(outs, 12'h000);
    cnt = 0;
    while (reset_busy_o === 1'b1 && cnt < 1000)
    begin
      step(1);
      cnt++;
    end
    `CHK(cnt, sysref_clk_pkg::RESET_QUIET_CYC);
    // host keeps the port quiet until busy drops
    regs_are(8'h80, 8'h00, 8'h10);
  endtask
  // ********************
  // run control
  // ********************
  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    rst_i = 1'b1;
    soft_reset_i = 1'b0;
    sysref_i = 1'b0;
    edge_position_i = '0;
    step(8);
    rst_i = 1'b0;
    step(4);
    t_defaults();
    t_fields();
    t_sysref();
    t_soft();
    `CHK(host.oe_bad, 0);
    tally_and_finish();
  end
  // about 8k cycles of frames expected
  initial
  begin
    step(40000);
    n_fail++;
    tally_and_finish();
  end
endmodule // sysref_clock_control_regs_test
